// ### src/charger_status_flags.sv
/*
 * Read-only charger status bank with its two-wire serial target.
 * Status levels arrive from analog circuits and are synchronised;
 * SCL and SDA arrive from pins; SDA is open drain (low when enabled).
 */
`timescale 1ns/1ps
module charger_status_flags #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary target address
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic firstAcInput,
    input wire logic busInputIn,
    input wire logic [2:0] chargePhaseIn,
    input wire logic [3:0] sourceTypeIn,
    input wire logic otgHotLimit,
    input wire logic otgColdLimit,
    input wire logic detectDoneIn,
    input wire logic [1:0] optimizerIn,
    input wire logic thermalIn,
    input wire logic dataLineIn,
    input wire logic batteryUvloRelease
);
    import charger_status_pkg::*;

    // Address zero is the broadcast call; a target there would answer
    // every controller on the bus, so it is refused at elaboration
    if (DEV_ADDR == 7'h00) begin : g_bad_addr
        $error("target address zero is not allowed");
    end

    // Serial pins: two flops, then one more for edge detection
    logic sclMeta_ff, sclSync_ff, sclLast_ff;
    logic sdaMeta_ff, sdaSync_ff, sdaLast_ff;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            {sclMeta_ff, sclSync_ff, sclLast_ff} <= 3'h7;
            {sdaMeta_ff, sdaSync_ff, sdaLast_ff} <= 3'h7;
        end else begin
            {sclMeta_ff, sclSync_ff, sclLast_ff} <=
                {sclIn, sclMeta_ff, sclSync_ff};
            {sdaMeta_ff, sdaSync_ff, sdaLast_ff} <=
                {sdaIn, sdaMeta_ff, sdaSync_ff};
        end
    end

    // Analog status bundle through two flops; all start at zero
    logic [RAW_WIDTH-1:0] rawIn, rawMeta_ff, raw_ff;
    assign rawIn = {firstAcInput, busInputIn, chargePhaseIn,
                    sourceTypeIn, otgHotLimit, otgColdLimit,
                    detectDoneIn, optimizerIn, thermalIn, dataLineIn,
                    batteryUvloRelease};
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rawMeta_ff <= '0;
            raw_ff <= '0;
        end else begin
            rawMeta_ff <= rawIn;
            raw_ff <= rawMeta_ff;
        end
    end

    // Legal-code filters; a reserved phase reports as the idle code, an illegal source type as SRC_NONE
    function automatic logic [2:0] phaseCode(input logic [2:0] p);
        phaseCode = (p == PHASE_RSVD) ? PHASE_IDLE : p;
    endfunction : phaseCode

    function automatic logic typeLegal(input logic [3:0] t);
        typeLegal = (t <= SRC_UNQUAL) || (t == SRC_DIRECT);
    endfunction : typeLegal

    // Synchronised fields
    logic firstInputPresent, busInputPresent, otgLimit;
    logic [2:0] rawPhase, chargePhase;
    logic [3:0] rawType, sourceType;
    logic chargerDetectDone, thermalActive, dataLineActive;
    logic batteryPresent, typeForcedZero;
    logic [1:0] rawOpt, optimizerState;
    assign firstInputPresent = raw_ff[16];
    assign busInputPresent = raw_ff[15];
    assign rawPhase = raw_ff[14:12];
    assign rawType = raw_ff[11:8];
    assign otgLimit = raw_ff[7] | raw_ff[6];
    assign chargerDetectDone = raw_ff[5];
    assign rawOpt = raw_ff[4:3];
    assign thermalActive = raw_ff[2];
    assign dataLineActive = raw_ff[1];
    assign batteryPresent = raw_ff[0];

    // Encoded fields with reserved and forced-zero cases folded in
    assign chargePhase = phaseCode(rawPhase);
    assign typeForcedZero = (otgLimit && rawType == SRC_OTG) ||
        (!busInputPresent && !firstInputPresent && rawType != SRC_OTG);
    assign sourceType = (typeForcedZero || !typeLegal(rawType)) ?
        SRC_NONE : rawType;
    assign optimizerState = (rawOpt == OPT_RSVD) ? OPT_OFF : rawOpt;

    // Register images; unused bits read zero
    logic [7:0] regPresence, regPhaseType, regOptTherm;
    assign regPresence = {6'h00, firstInputPresent,
                          busInputPresent};
    assign regPhaseType = {chargePhase, sourceType,
                           chargerDetectDone};
    assign regOptTherm = {optimizerState, RSVD_FIELD, thermalActive,
                          dataLineActive, batteryPresent};

    // Read decode, used at every byte load
    function automatic logic [7:0] regRead(input logic [7:0] a,
        input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2);
        case (a)
            OFS_PRESENCE: regRead = r0;
            OFS_PHASE_TYPE: regRead = r1;
            OFS_OPT_THERM: regRead = r2;
            default: regRead = RESET_VALUE;
        endcase
    endfunction : regRead

    // Bus events seen on the synchronised pins
    logic sclRise, sclFall, startSeen, stopSeen, byteDone, addrHit;
    logic [7:0] readByte;
    assign sclRise = sclSync_ff & ~sclLast_ff;
    assign sclFall = ~sclSync_ff & sclLast_ff;
    assign startSeen = sclSync_ff & sclLast_ff & sdaLast_ff & ~sdaSync_ff;
    assign stopSeen = sclSync_ff & sclLast_ff & ~sdaLast_ff & sdaSync_ff;

    link_state_t state_ff;
    logic [3:0] bitCnt_ff;
    logic [7:0] shift_ff, txShift_ff, ptr_ff;
    logic rdMode_ff, sdaOe_ff;
    assign byteDone = (bitCnt_ff == BITS_PER_BYTE);
    assign addrHit = (shift_ff[7:1] == DEV_ADDR);
    assign readByte = regRead(ptr_ff, regPresence, regPhaseType,
                              regOptTherm);

    // Open-drain SDA: only ever pulled low
    assign sdaOut = SDA_LOW;
    assign sdaOe = sdaOe_ff;

    // Shift register on SCL rising; bit count on SCL rising, or on SCL falling in read data
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shift_ff <= 8'h00;
            bitCnt_ff <= 4'h0;
        end else if (startSeen) begin
            bitCnt_ff <= 4'h0;
        end else if (sclRise && (state_ff == S_ADDR ||
                     state_ff == S_PTR || state_ff == S_WDATA)) begin
            shift_ff <= {shift_ff[6:0], sdaSync_ff};
            bitCnt_ff <= bitCnt_ff + 4'h1;
        end else if (sclFall && !byteDone && state_ff == S_RDATA) begin
            bitCnt_ff <= bitCnt_ff + 4'h1;
        end else if (sclFall && state_ff != S_RDATA &&
                     state_ff != S_ADDR && state_ff != S_PTR &&
                     state_ff != S_WDATA) begin
            bitCnt_ff <= 4'h0;
        end
    end

    // Transfer sequencer; writes to data bytes are acked and dropped
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= S_IDLE;
            sdaOe_ff <= 1'b0;
            rdMode_ff <= 1'b0;
            ptr_ff <= 8'h00;
            txShift_ff <= 8'h00;
        end else if (startSeen) begin
            state_ff <= S_ADDR;
            sdaOe_ff <= 1'b0;
        end else if (stopSeen) begin
            state_ff <= S_IDLE;
            sdaOe_ff <= 1'b0;
        end else if (sclRise && state_ff == S_RDATA_ACK && sdaSync_ff) begin
            state_ff <= S_IDLE; // Controller declined more data
        end else if (sclFall) begin
            case (state_ff)
                S_ADDR: begin
                    if (byteDone && addrHit) begin
                        state_ff <= S_ADDR_ACK;
                        sdaOe_ff <= 1'b1;
                        rdMode_ff <= shift_ff[0];
                    end else if (byteDone) begin
                        state_ff <= S_IDLE;
                    end
                end
                S_ADDR_ACK, S_RDATA_ACK: begin
                    if (rdMode_ff) begin
                        state_ff <= S_RDATA;
                        txShift_ff <= readByte;
                        sdaOe_ff <= ~readByte[7];
                    end else begin
                        state_ff <= S_PTR;
                        sdaOe_ff <= 1'b0;
                    end
                end
                S_PTR: begin
                    if (byteDone) begin
                        state_ff <= S_PTR_ACK;
                        ptr_ff <= shift_ff;
                        sdaOe_ff <= 1'b1;
                    end
                end
                S_PTR_ACK, S_WDATA_ACK: begin
                    state_ff <= S_WDATA;
                    sdaOe_ff <= 1'b0;
                end
                S_WDATA: begin
                    if (byteDone) begin
                        state_ff <= S_WDATA_ACK;
                        ptr_ff <= ptr_ff + 8'h01;
                        sdaOe_ff <= 1'b1;
                    end
                end
                S_RDATA: begin
                    if (bitCnt_ff == BITS_PER_BYTE - 4'h1) begin
                        state_ff <= S_RDATA_ACK;
                        ptr_ff <= ptr_ff + 8'h01;
                        sdaOe_ff <= 1'b0;
                    end else begin
                        txShift_ff <= {txShift_ff[6:0], 1'b0};
                        sdaOe_ff <= ~txShift_ff[6];
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                    sdaOe_ff <= 1'b0;
                end
            endcase
        end
    end

    // Checks on status encoding and the serial read path
    sequence addrMatch;
        state_ff == S_ADDR && sclFall && byteDone && addrHit;
    endsequence
    sequence byteLoad;
        sclFall && rdMode_ff && !startSeen && !stopSeen &&
        (state_ff == S_ADDR_ACK || state_ff == S_RDATA_ACK);
    endsequence

    a_first_present: assert property (@(posedge clock)
        disable iff (!reset_n) regPresence[BIT_FIRST_PRESENT] ==
        $past(firstAcInput, 2)) else $error("first input bit wrong");
    a_bus_present: assert property (@(posedge clock)
        disable iff (!reset_n) regPresence[BIT_BUS_PRESENT] ==
        $past(busInputIn, 2)) else $error("bus input bit wrong");
    a_phase_code: assert property (@(posedge clock)
        disable iff (!reset_n) chargePhase != PHASE_RSVD and
        ($past(chargePhaseIn, 2) != PHASE_RSVD |->
        regPhaseType[7:5] == $past(chargePhaseIn, 2)))
        else $error("charge phase wrong");
    a_phase_reset: assert property (@(posedge clock)
        !reset_n |-> chargePhase == PHASE_IDLE)
        else $error("charge phase not zero in reset");
    a_type_zero: assert property (@(posedge clock)
        disable iff (!reset_n) (($past(otgHotLimit, 2) ||
        $past(otgColdLimit, 2)) && $past(sourceTypeIn, 2) == SRC_OTG) ||
        (!$past(busInputIn, 2) && !$past(firstAcInput, 2) &&
        $past(sourceTypeIn, 2) != SRC_OTG) |->
        regPhaseType[4:1] == SRC_NONE)
        else $error("source type not forced to zero");
    a_type_legal: assert property (@(posedge clock)
        disable iff (!reset_n) sourceType <= SRC_NONSTD ||
        sourceType == SRC_OTG || sourceType == SRC_UNQUAL ||
        sourceType == SRC_DIRECT) else $error("reserved source type");
    a_type_direct: assert property (@(posedge clock)
        disable iff (!reset_n) (rawType == SRC_DIRECT && busInputPresent)
        |-> regPhaseType[4:1] == SRC_DIRECT)
        else $error("direct source code lost");
    a_otg_code: assert property (@(posedge clock)
        disable iff (!reset_n) (rawType == SRC_OTG && !otgLimit) |->
        regPhaseType[4:1] == SRC_OTG) else $error("OTG source code lost");
    a_detect_done: assert property (@(posedge clock)
        disable iff (!reset_n) regPhaseType[0] == $past(detectDoneIn, 2))
        else $error("detect done bit wrong");
    a_optimizer: assert property (@(posedge clock)
        disable iff (!reset_n) regOptTherm[7:6] != OPT_RSVD and
        ($past(optimizerIn, 2) != OPT_RSVD |->
        regOptTherm[7:6] == $past(optimizerIn, 2)))
        else $error("optimizer field wrong");
    a_reserved_zero: assert property (@(posedge clock)
        disable iff (!reset_n) byteLoad ##0 (ptr_ff == OFS_OPT_THERM)
        |=> txShift_ff[5:3] == RSVD_FIELD)
        else $error("reserved bits not zero");
    a_thermal_bit: assert property (@(posedge clock)
        disable iff (!reset_n) regOptTherm[BIT_THERMAL] ==
        $past(thermalIn, 2)) else $error("thermal bit wrong");
    a_data_line: assert property (@(posedge clock)
        disable iff (!reset_n) regOptTherm[BIT_DATA_LINE] ==
        $past(dataLineIn, 2)) else $error("data line bit wrong");
    a_battery_bit: assert property (@(posedge clock)
        disable iff (!reset_n) regOptTherm[BIT_BATTERY] ==
        $past(batteryUvloRelease, 2)) else $error("battery bit wrong");
    a_read_live: assert property (@(posedge clock)
        disable iff (!reset_n) byteLoad |=> txShift_ff == $past(readByte)
        ##0 sdaOe_ff == ~txShift_ff[7]) else $error("read data not live");
    a_unmapped_zero: assert property (@(posedge clock)
        disable iff (!reset_n) byteLoad ##0 (ptr_ff < OFS_PRESENCE ||
        ptr_ff > OFS_OPT_THERM) |=> txShift_ff == RESET_VALUE)
        else $error("unmapped read not zero");
    a_stop_idle: assert property (@(posedge clock)
        disable iff (!reset_n) stopSeen |=> state_ff == S_IDLE &&
        !sdaOe_ff) else $error("stop did not release the bus");
    a_start_addr: assert property (@(posedge clock)
        disable iff (!reset_n) startSeen |=> state_ff == S_ADDR &&
        bitCnt_ff == 4'h0) else $error("start did not restart the byte");
    a_addr_ack: assert property (@(posedge clock)
        disable iff (!reset_n) addrMatch |=> sdaOe_ff &&
        state_ff == S_ADDR_ACK) else $error("address not acknowledged");
endmodule : charger_status_flags

// ### src/charger_status_pkg.sv
/*
 * Constants for the charger status register bank: offsets, field
 * positions, codes and the serial-target state type.
 * Assumes the bank sits behind a two-wire serial target in one clock.
 */
package charger_status_pkg;
    localparam logic [7:0] OFS_PRESENCE = 8'h1B;
    localparam logic [7:0] OFS_PHASE_TYPE = 8'h1C;
    localparam logic [7:0] OFS_OPT_THERM = 8'h1D;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // Field positions
    localparam int BIT_FIRST_PRESENT = 1;
    localparam int BIT_BUS_PRESENT = 0;
    localparam int BIT_THERMAL = 2;
    localparam int BIT_DATA_LINE = 1;
    localparam int BIT_BATTERY = 0;
    localparam logic [2:0] RSVD_FIELD = 3'h0;
    // Charge phase codes
    localparam logic [2:0] PHASE_IDLE = 3'h0;
    localparam logic [2:0] PHASE_RSVD = 3'h5;
    // Input source type codes
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_NONSTD = 4'h6;
    localparam logic [3:0] SRC_OTG = 4'h7;
    localparam logic [3:0] SRC_UNQUAL = 4'h8;
    localparam logic [3:0] SRC_DIRECT = 4'hB;
    // Optimizer codes
    localparam logic [1:0] OPT_OFF = 2'h0;
    localparam logic [1:0] OPT_RSVD = 2'h3;
    // Serial link: bits per byte, open-drain low level
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic SDA_LOW = 1'b0;
    // Width of the raw status bundle from the analog side
    localparam int RAW_WIDTH = 17;

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK,
        S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK
    } link_state_t;
endpackage : charger_status_pkg

// ### tb/charger_status_flags_bench.sv
/*
 * Self-checking bench for the charger status bank: random status
 * levels with every phase and source code, burst reads, writes,
 * unmapped and foreign-address accesses. Assumes SDA pull-up.
 */
`timescale 1ns/1ps
module charger_status_flags_bench;
    import charger_status_pkg::*;
    localparam logic [6:0] TARGET = 7'h2A; // Arbitrary target address
    logic clock;
    logic reset_n = 1'b1;
    logic sclOut, hostLow, sdaOut, sdaOe;
    logic fa = 1'b0, bus = 1'b0, hot = 1'b0;
    logic cold = 1'b0, done = 1'b0, therm = 1'b0, dl = 1'b0, batt = 1'b0;
    logic [2:0] phase = '0;
    logic [3:0] srcType = '0;
    logic [1:0] opt = '0;
    logic [23:0] rd;
    logic acked;
    logic [2:0] acks;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    // Open-drain wire with pull-up
    wire logic sdaWire = ~((sdaOe & ~sdaOut) | hostLow);

    charger_status_flags #(.DEV_ADDR(TARGET)) i_charger_status_flags (
        .clock(clock), .reset_n(reset_n), .sclIn(sclOut),
        .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .firstAcInput(fa), .busInputIn(bus), .chargePhaseIn(phase),
        .sourceTypeIn(srcType), .otgHotLimit(hot), .otgColdLimit(cold),
        .detectDoneIn(done), .optimizerIn(opt), .thermalIn(therm),
        .dataLineIn(dl), .batteryUvloRelease(batt));
    status_reader_model #(.DEV_ADDR(TARGET)) i_status_reader_model (
        .clock(clock), .sdaWire(sdaWire), .sclOut(sclOut),
        .sdaLow(hostLow));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time,
                     seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // Expected source code: reserved, OTG with a limit and non-OTG with no input give zero
    function automatic logic [3:0] expType();
        logic [3:0] t;
        t = srcType;
        if (t == 4'h9 || t == 4'hA || t >= 4'hC) t = 4'h0;
        if (t == 4'h7 && (hot | cold)) t = 4'h0;
        if (t != 4'h7 && !fa && !bus) t = 4'h0;
        return t;
    endfunction : expType

    function automatic logic [7:0] expPhaseType();
        return {(phase == 3'h5) ? 3'h0 : phase, expType(), done};
    endfunction : expPhaseType

    function automatic logic [7:0] expOpt();
        return {(opt == 2'h3) ? 2'h0 : opt, 3'h0, therm, dl, batt};
    endfunction : expOpt

    // Read all three registers in one burst and compare
    task automatic readAll();
        i_status_reader_model.readRegs(8'h1B, 3, rd, acked);
        check({7'h00, acked}, 8'h01);
        check(rd[23:16], {6'h00, fa, bus});
        check(rd[15:8], expPhaseType());
        check(rd[7:0], expOpt());
    endtask : readAll

    // Type code steps through all 16, phase through all 8
    task automatic setInputs(input int i);
        logic [31:0] r;
        r = $urandom;
        @(posedge clock);
        fa <= r[0];
        bus <= r[1];
        hot <= i[4] & i[0];
        cold <= r[2] & r[3];
        done <= r[4];
        opt <= r[6:5];
        therm <= r[7];
        dl <= r[8];
        batt <= r[9];
        phase <= i[2:0];
        srcType <= i[3:0];
        repeat (4) @(posedge clock);
    endtask : setInputs

    // Cut a hang short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        reset_n <= 1'b0; // Falling edge before the first clock resets all
        void'($urandom(32'h2ab4));
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        i_status_reader_model.readRegs(8'h1C, 1, rd, acked);
        check(rd[7:0], 8'h00);
        for (int i = 0; i < 32; i++) begin
            setInputs(i);
            readAll();
        end
        i_status_reader_model.writeTo(TARGET, 8'h1C, 8'hFF, acks);
        check({5'h00, acks}, 8'h07);
        readAll();
        i_status_reader_model.readRegs(8'h20, 1, rd, acked);
        check(rd[7:0], 8'h00);
        i_status_reader_model.writeTo(TARGET ^ 7'h01, 8'h1C, 8'h00, acks);
        check({5'h00, acks}, 8'h00);
        print_verdict();
    end
endmodule : charger_status_flags_bench

// ### tb/status_reader_model.sv
/*
 * Host model that reads and writes the status bank over the two-wire
 * serial link. Assumes a pull-up on SDA resolved by the bench and the
 * bench clock; every pin change after the blocking idle setup lands by non-blocking assignment.
 */
`timescale 1ns/1ps
module status_reader_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary target address
) (
    input wire logic clock,
    input wire logic sdaWire,
    output logic sclOut,
    output logic sdaLow
);
    localparam int HALF = 8; // Clocks per SCL phase, twice the minimum

    // Idle bus: SCL high, SDA released
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic pause(input int n);
        repeat (n) @(posedge clock);
    endtask : pause

    // Start or repeated start: SDA falls while SCL is high
    task automatic startCond();
        sdaLow <= 1'b0;
        pause(HALF);
        sclOut <= 1'b1;
        pause(HALF);
        sdaLow <= 1'b1;
        pause(HALF);
        sclOut <= 1'b0;
        pause(HALF);
    endtask : startCond

    task automatic stopCond();
        sdaLow <= 1'b1;
        pause(HALF);
        sclOut <= 1'b1;
        pause(HALF);
        sdaLow <= 1'b0;
        pause(HALF);
    endtask : stopCond

    // Eight bits MSB first plus the ninth; SDA moves 2 clocks after SCL
    task automatic xferByte(input logic [7:0] tx, input logic hostAck,
                            output logic [7:0] rx, output logic devAck);
        logic [8:0] bits;
        logic [8:0] seen;
        bits = {tx, hostAck};
        for (int i = 8; i >= 0; i--) begin
            sdaLow <= ~bits[i];
            pause(HALF);
            sclOut <= 1'b1;
            pause(HALF);
            seen[i] = sdaWire;
            sclOut <= 1'b0;
            pause(2);
        end
        rx = seen[8:1];
        devAck = ~seen[0];
    endtask : xferByte

    // Set pointer, restart, read n bytes; last byte gets NACK
    task automatic readRegs(input logic [7:0] ofs, input int n,
                            output logic [23:0] data, output logic acked);
        logic a;
        logic [7:0] rx;
        acked = 1'b1;
        data = '0;
        startCond();
        xferByte({DEV_ADDR, 1'b0}, 1'b1, rx, a);
        acked &= a;
        xferByte(ofs, 1'b1, rx, a);
        acked &= a;
        startCond();
        xferByte({DEV_ADDR, 1'b1}, 1'b1, rx, a);
        acked &= a;
        for (int k = 0; k < n; k++) begin
            xferByte(8'hFF, k == n - 1, rx, a);
            data = {data[15:0], rx};
        end
        stopCond();
    endtask : readRegs

    // Address, pointer and one data byte to any target address
    task automatic writeTo(input logic [6:0] addr, input logic [7:0] ofs,
                           input logic [7:0] val, output logic [2:0] acks);
        logic [7:0] rx;
        startCond();
        xferByte({addr, 1'b0}, 1'b1, rx, acks[2]);
        xferByte(ofs, 1'b1, rx, acks[1]);
        xferByte(val, 1'b1, rx, acks[0]);
        stopCond();
    endtask : writeTo
endmodule : status_reader_model
